// >>> core/cbf_defines.svh
// Constants for the breaker-failure supervisor: widths, offsets, fields, resets.
`ifndef CBF_DEFINES_SVH
`define CBF_DEFINES_SVH
// Data widths.
`define CBF_DLY_W     16
`define CBF_CNT_W     16
`define CBF_STAMP_W   48
`define CBF_CUR_W     16
`define CBF_GRP_W     3
`define CBF_EV_W      4
`define CBF_NEV       8
`define CBF_NTMR      2
`define CBF_NCNT      4
`define CBF_ADDR_W    8
`define CBF_DATA_W    32
// Record buffer geometry.
`define CBF_REC_DEPTH 12
`define CBF_REC_AW    4
`define CBF_REC_W     128
`define CBF_REC_PAD   9
`define CBF_REC_LAST  4'hB
`define CBF_REC_FULL  4'hC
// Register byte offsets.
`define CBF_A_CTRL    8'h00
`define CBF_A_RTR_DLY 8'h04
`define CBF_A_FL_DLY  8'h08
`define CBF_A_STATUS  8'h0C
`define CBF_A_CNT_CLR 8'h10
`define CBF_A_CNT_A   8'h14
`define CBF_A_CNT_B   8'h18
`define CBF_A_REC_SEL 8'h1C
`define CBF_A_REC_W0  8'h20
`define CBF_A_REC_W1  8'h24
`define CBF_A_REC_W2  8'h28
`define CBF_A_REC_W3  8'h2C
// Control register fields.
`define CBF_F_MODE    1:0
`define CBF_F_RTR_EN  2
`define CBF_F_ONM     15:8
`define CBF_F_OFFM    23:16
// Status bit positions, shared by events and counters.
`define CBF_S_START   0
`define CBF_S_RETRIP  1
`define CBF_S_FAIL    2
`define CBF_S_BLOCK   3
// Timer indices.
`define CBF_T_RTR     0
`define CBF_T_FAIL    1
// Reset values; delays are in program-cycle ticks.
`define CBF_RST_RTR   16'h0014
`define CBF_RST_FAIL  16'h0028
`define CBF_RST_MASK  8'hFF
`define CBF_RST_CTRL  32'h00FFFF04
`endif

// >>> core/cbf_pkg.sv
// Types shared by the breaker-failure supervisor files.
package cbf_pkg;
  // Selectable start criterion of the delay timers.
  typedef enum logic [1:0] {
    MODE_CURRENT,
    MODE_CUR_AND_OUT,
    MODE_CUR_OR_OUT,
    MODE_INPUT
  } criterion_t;
endpackage

// >>> core/record_mem.sv
// Twelve-entry operation record store with a registered read port.
`timescale 1ns/100ps
`include "cbf_defines.svh"
module record_mem (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     wr_en_i,
  input  wire logic [`CBF_REC_AW-1:0]   wr_addr_i,
  input  wire logic [`CBF_REC_W-1:0]    wr_data_i,
  input  wire logic [`CBF_REC_AW-1:0]   rd_addr_i,
  output logic      [`CBF_REC_W-1:0]    rd_data_o
);
  // Storage array; contents are undefined until first written.
  logic [`CBF_REC_W-1:0] mem [`CBF_REC_DEPTH];

  // Write port.
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read port; out-of-range slots read as zero.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (rd_addr_i <= `CBF_REC_LAST) begin
      rd_data_o <= mem[rd_addr_i];
    end else begin
      rd_data_o <= '0;
    end
  end
endmodule

// >>> core/breaker_failure_supervisor.sv
// Breaker-failure supervisor: delay timers, events, counters and records.
`timescale 1ns/100ps
`include "cbf_defines.svh"
module breaker_failure_supervisor (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     tick_i,
  input  wire logic                     phase_pickup_i,
  input  wire logic                     residual_pickup_i,
  input  wire logic                     trip_monitor_i,
  input  wire logic                     dedicated_input_i,
  input  wire logic                     block_i,
  input  wire logic [`CBF_STAMP_W-1:0]  timestamp_i,
  input  wire logic [`CBF_CUR_W-1:0]    max_phase_current_i,
  input  wire logic [`CBF_CUR_W-1:0]    residual_current_i,
  input  wire logic [`CBF_GRP_W-1:0]    setting_group_i,
  input  wire logic [`CBF_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [`CBF_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [`CBF_DATA_W-1:0]   reg_rdata_o,
  output logic                          breaker_failure_output_o,
  output logic                          retrip_o,
  output logic                          start_o,
  output logic                          blocked_o,
  output logic                          event_valid_o,
  output logic      [`CBF_EV_W-1:0]     event_code_o,
  output logic      [`CBF_STAMP_W-1:0]  event_stamp_o
);
  import cbf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [`CBF_DATA_W-1:0] ctrl;                // Mode, retrip enable, masks.
  logic [`CBF_DLY_W-1:0]  dly [`CBF_NTMR];     // Retrip and failure delays.
  logic [`CBF_REC_AW-1:0] rec_sel;             // Record slot shown on the bus.
  criterion_t             mode;                // Decoded criterion.
  wire                    retrip_en = ctrl[`CBF_F_RTR_EN];
  wire [`CBF_NEV-1:0]     on_mask   = ctrl[`CBF_F_ONM];
  wire [`CBF_NEV-1:0]     off_mask  = ctrl[`CBF_F_OFFM];
  assign mode = criterion_t'(ctrl[`CBF_F_MODE]);

  // Write decode.
  wire wr_ctrl = reg_wr_i && (reg_addr_i == `CBF_A_CTRL);
  wire wr_rtr  = reg_wr_i && (reg_addr_i == `CBF_A_RTR_DLY);
  wire wr_fail = reg_wr_i && (reg_addr_i == `CBF_A_FL_DLY);
  wire wr_clr  = reg_wr_i && (reg_addr_i == `CBF_A_CNT_CLR);
  wire wr_sel  = reg_wr_i && (reg_addr_i == `CBF_A_REC_SEL);
  wire [`CBF_NCNT-1:0] cnt_clr = wr_clr ? reg_wdata_i[`CBF_NCNT-1:0] : '0;

  // Software-written configuration; reset gives current mode, retrip on.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl               <= `CBF_RST_CTRL;
      dly[`CBF_T_RTR]    <= `CBF_RST_RTR;
      dly[`CBF_T_FAIL]   <= `CBF_RST_FAIL;
      rec_sel            <= '0;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata_i;
      if (wr_rtr)  dly[`CBF_T_RTR]  <= reg_wdata_i[`CBF_DLY_W-1:0];
      if (wr_fail) dly[`CBF_T_FAIL] <= reg_wdata_i[`CBF_DLY_W-1:0];
      if (wr_sel)  rec_sel <= reg_wdata_i[`CBF_REC_AW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pick-up criterion and blocking.

  wire cur_up = phase_pickup_i | residual_pickup_i;  // Either current element up.
  logic pick_raw;   // Function picked up (shown as start unless blocked).
  logic run_raw;    // Condition under which the timers may advance.

  // Criterion selection.
  always_comb begin
    pick_raw = 1'b0;
    run_raw  = 1'b0;
    unique case (mode)
      MODE_CURRENT: begin
        pick_raw = cur_up;
        run_raw  = cur_up;
      end
      MODE_CUR_AND_OUT: begin
        pick_raw = cur_up;
        run_raw  = cur_up & trip_monitor_i;
      end
      MODE_CUR_OR_OUT: begin
        pick_raw = cur_up | trip_monitor_i;
        run_raw  = cur_up | trip_monitor_i;
      end
      MODE_INPUT: begin
        pick_raw = dedicated_input_i;
        run_raw  = dedicated_input_i;
      end
    endcase
  end

  logic blocked;  // Blocked indication, held while pick-up lasts.
  wire next_blocked = pick_raw & (blocked | block_i);
  // Timers only run when neither blocked nor being blocked now.
  wire run_eff = run_raw & ~block_i & ~blocked;

  //////////////////////////////////////////////////////////////////////////////
  // Delay timers; index 0 is retrip, index 1 is failure.

  logic [`CBF_NTMR-1:0][`CBF_DLY_W-1:0] tcnt;     // Accumulated ticks.
  logic [`CBF_NTMR-1:0]                 expired;  // Timer at its delay.

  for (genvar t = 0; t < `CBF_NTMR; t++) begin : g_tmr
    wire at_end = (tcnt[t] == dly[t]);
    wire [`CBF_DLY_W-1:0] next_tcnt =
        !run_eff            ? '0 :
        (tick_i && !at_end) ? `CBF_DLY_W'(tcnt[t] + 1'b1) : tcnt[t];
    assign expired[t] = run_eff & at_end;
    // Counter register; cleared at once whenever the run condition fails.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        tcnt[t] <= '0;
      end else begin
        tcnt[t] <= next_tcnt;
      end
    end
  end

  wire next_fail   = expired[`CBF_T_FAIL];
  wire next_retrip = expired[`CBF_T_RTR] & retrip_en;
  wire next_start  = pick_raw & ~next_blocked;

  //////////////////////////////////////////////////////////////////////////////
  // Status signals and edge detection.

  logic [`CBF_NEV-1:0] st;  // Registered status, one bit per event pair.
  wire [`CBF_NEV-1:0] next_st = {residual_pickup_i, phase_pickup_i,
                                 dedicated_input_i, trip_monitor_i,
                                 next_blocked, next_fail, next_retrip, next_start};
  wire [`CBF_NEV-1:0] rise = next_st & ~st;
  wire [`CBF_NEV-1:0] fall = ~next_st & st;

  // Outputs straight from status flops.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st                       <= '0;
      blocked                  <= 1'b0;
      breaker_failure_output_o <= 1'b0;
      retrip_o                 <= 1'b0;
      start_o                  <= 1'b0;
      blocked_o                <= 1'b0;
    end else begin
      st                       <= next_st;
      blocked                  <= next_blocked;
      breaker_failure_output_o <= next_fail;
      retrip_o                 <= next_retrip;
      start_o                  <= next_start;
      blocked_o                <= next_blocked;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event queue: one pending bit per edge, drained lowest first.

  logic [2*`CBF_NEV-1:0] pend;    // Bits 0..7 ON edges, 8..15 OFF edges.
  logic [2*`CBF_NEV-1:0] grant;   // One-hot bit being emitted.
  logic [`CBF_EV_W-1:0]  ev_code; // Code of the granted bit.
  wire  [2*`CBF_NEV-1:0] ev_mask = {off_mask, on_mask};

  // Lowest-set-bit priority pick.
  always_comb begin
    grant   = '0;
    ev_code = '0;
    for (int i = 2*`CBF_NEV-1; i >= 0; i--) begin
      if (pend[i]) begin
        grant   = '0;
        grant[i] = 1'b1;
        ev_code = `CBF_EV_W'(i);
      end
    end
  end

  // New edges win over the grant that drains the same bit.
  wire [2*`CBF_NEV-1:0] next_pend = (pend & ~grant) | {fall, rise};
  wire ev_any = |pend;
  wire ev_on  = ev_any & ~ev_code[`CBF_EV_W-1];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pend          <= '0;
      event_valid_o <= 1'b0;
      event_code_o  <= '0;
      event_stamp_o <= '0;
    end else begin
      pend          <= next_pend;
      event_valid_o <= |(grant & ev_mask);
      event_code_o  <= ev_code;
      event_stamp_o <= timestamp_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cumulative counters on start, retrip, failure and blocked rising edges.

  logic [`CBF_NCNT-1:0][`CBF_CNT_W-1:0] cnt;

  for (genvar k = 0; k < `CBF_NCNT; k++) begin : g_cnt
    wire [`CBF_CNT_W-1:0] next_cnt =
        rise[k]    ? (cnt_clr[k] ? `CBF_CNT_W'(1) : `CBF_CNT_W'(cnt[k] + 1'b1)) :
        cnt_clr[k] ? '0 : cnt[k];
    // Counter register; an edge in the clearing cycle still counts.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        cnt[k] <= '0;
      end else begin
        cnt[k] <= next_cnt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operation records, written for every ON event leaving the queue.

  logic [`CBF_REC_AW-1:0] rec_wptr;   // Slot written next (oldest when full).
  logic [`CBF_REC_AW-1:0] rec_fill;   // Number of valid slots.
  logic [`CBF_REC_W-1:0]  rec_rdata;  // Selected record.
  wire  [`CBF_REC_W-1:0]  rec_wdata = {{`CBF_REC_PAD{1'b0}}, setting_group_i,
                                       ev_code, residual_current_i,
                                       `CBF_DLY_W'(dly[`CBF_T_FAIL] - tcnt[`CBF_T_FAIL]),
                                       `CBF_DLY_W'(dly[`CBF_T_RTR] - tcnt[`CBF_T_RTR]),
                                       max_phase_current_i, timestamp_i};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rec_wptr <= '0;
      rec_fill <= '0;
    end else if (ev_on) begin
      rec_wptr <= (rec_wptr == `CBF_REC_LAST) ? '0 : `CBF_REC_AW'(rec_wptr + 1'b1);
      if (rec_fill != `CBF_REC_FULL) rec_fill <= `CBF_REC_AW'(rec_fill + 1'b1);
    end
  end

  record_mem u_rec (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_en_i   (ev_on),
    .wr_addr_i (rec_wptr),
    .wr_data_i (rec_wdata),
    .rd_addr_i (rec_sel),
    .rd_data_o (rec_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read-back multiplexer; unmapped addresses read as zero.

  wire [`CBF_DATA_W-1:0] status_word =
      `CBF_DATA_W'({rec_wptr, rec_fill, st[`CBF_S_BLOCK:`CBF_S_START]});
  logic [`CBF_DATA_W-1:0] rd_mux;
  always_comb begin
    unique case (reg_addr_i)
      `CBF_A_CTRL:    rd_mux = ctrl;
      `CBF_A_RTR_DLY: rd_mux = `CBF_DATA_W'(dly[`CBF_T_RTR]);
      `CBF_A_FL_DLY:  rd_mux = `CBF_DATA_W'(dly[`CBF_T_FAIL]);
      `CBF_A_STATUS:  rd_mux = status_word;
      `CBF_A_CNT_A:   rd_mux = {cnt[`CBF_S_RETRIP], cnt[`CBF_S_START]};
      `CBF_A_CNT_B:   rd_mux = {cnt[`CBF_S_BLOCK], cnt[`CBF_S_FAIL]};
      `CBF_A_REC_SEL: rd_mux = `CBF_DATA_W'(rec_sel);
      `CBF_A_REC_W0:  rd_mux = rec_rdata[0 +: `CBF_DATA_W];
      `CBF_A_REC_W1:  rd_mux = rec_rdata[`CBF_DATA_W +: `CBF_DATA_W];
      `CBF_A_REC_W2:  rd_mux = rec_rdata[2*`CBF_DATA_W +: `CBF_DATA_W];
      `CBF_A_REC_W3:  rd_mux = rec_rdata[3*`CBF_DATA_W +: `CBF_DATA_W];
      default:        rd_mux = '0;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the supervision behaviour.

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  cur_fail_a: assert property (mode == MODE_CURRENT && next_fail |-> cur_up)
    else $error("current mode failure without current");
  cur_clear_a: assert property (mode == MODE_CURRENT && !cur_up |=> tcnt == '0)
    else $error("current mode counter not cleared");
  and_freeze_a: assert property (mode == MODE_CUR_AND_OUT && !trip_monitor_i
      |=> tcnt == '0)
    else $error("counter ran before trip monitored");
  and_fail_a: assert property (mode == MODE_CUR_AND_OUT && next_fail
      |-> cur_up && trip_monitor_i)
    else $error("and mode failure without both");
  and_clear_a: assert property (mode == MODE_CUR_AND_OUT && !cur_up |=> tcnt == '0)
    else $error("and mode counter not cleared");
  or_hold_a: assert property (mode == MODE_CUR_OR_OUT && run_eff && tick_i
      && tcnt[1] != dly[1] |=> tcnt[1] == $past(tcnt[1]) + 1'b1)
    else $error("or mode counter did not advance");
  or_start_a: assert property (mode == MODE_CUR_OR_OUT && trip_monitor_i
      && !block_i && !blocked |=> start_o)
    else $error("or mode trip did not start");
  input_only_a: assert property (mode == MODE_INPUT && !dedicated_input_i
      |=> tcnt == '0 && !start_o)
    else $error("input mode ran without input");
  block_rel_a: assert property (block_i |=> tcnt == '0 && !breaker_failure_output_o)
    else $error("block did not release timing");
  tick_step_a: assert property (!tick_i && run_eff |=> tcnt == $past(tcnt))
    else $error("counter moved without tick");
  expire_a: assert property (run_eff && tcnt[1] == dly[1] |=> breaker_failure_output_o)
    else $error("failure not raised at delay");
  count_a: assert property (rise[2] && !cnt_clr[2]
      |=> cnt[2] == $past(cnt[2]) + 1'b1)
    else $error("failure count did not increment");
  rec_wrap_a: assert property (ev_on && rec_wptr == `CBF_REC_LAST |=> rec_wptr == '0)
    else $error("record pointer did not wrap");
  ev_mask_a: assert property (grant[0] && !on_mask[0] |=> !event_valid_o)
    else $error("masked event emitted");
  stamp_a: assert property (ev_any |=> event_stamp_o == $past(timestamp_i))
    else $error("event stamp mismatch");

  fail_c: cover property ($rose(breaker_failure_output_o));
  retrip_c: cover property ($rose(retrip_o) ##[1:100] $rose(breaker_failure_output_o));
  blocked_c: cover property ($rose(blocked_o));
  wrap_c: cover property (ev_on && rec_wptr == `CBF_REC_LAST);
endmodule

// >>> bench/breaker_plant.sv
// Model of the protected feeder: fault current, primary trip contact and breaker.
`timescale 1ns/100ps
module breaker_plant #(
  parameter int OPEN_TICKS = 1
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic fault_i,
  input  wire logic trip_cmd_i,
  input  wire logic breaker_ok_i,
  output logic      phase_pickup_o,
  output logic      residual_pickup_o,
  output logic      trip_monitor_o
);
  logic       closed;    // Breaker poles closed, so fault current flows.
  logic [3:0] open_cnt;  // Ticks since a trip reached a healthy breaker.

  ////////////////////////////////////////////////////////////////////////////////
  // A healthy breaker opens some ticks after the trip; a failed one never does.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      closed            <= 1'h1;
      open_cnt          <= 4'h0;
      phase_pickup_o    <= 1'h0;
      residual_pickup_o <= 1'h0;
      trip_monitor_o    <= 1'h0;
    end else begin
      if (trip_cmd_i && breaker_ok_i && closed) begin
        if (tick_i) begin
          open_cnt <= open_cnt + 4'h1;
        end
        if (open_cnt == 4'(OPEN_TICKS)) begin
          closed <= 1'h0;
        end
      end else if (!trip_cmd_i && !fault_i) begin
        // The breaker is closed again once the feeder is healthy.
        closed   <= 1'h1;
        open_cnt <= 4'h0;
      end
      // Current flows only through a closed breaker; the contact follows the trip.
      phase_pickup_o    <= fault_i && closed;
      residual_pickup_o <= fault_i && closed;
      trip_monitor_o    <= trip_cmd_i;
    end
  end
endmodule

// >>> bench/breaker_failure_supervisor_test.sv
// Self-checking testbench of the breaker-failure supervisor.
`timescale 1ns/100ps
`include "cbf_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %0h seen %0h", nm, (e), (g)); end end
module breaker_failure_supervisor_test;
  import cbf_pkg::*;
  logic        clk_sys_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        tick_i = 1'h0;
  logic [1:0]  div = 2'h0;                  // Program-cycle divider.
  logic [47:0] ts = 48'h0;                  // Free-running time stamp.
  logic        fault = 1'h0, trip_cmd = 1'h0, brk_ok = 1'h1;
  logic        ded_in = 1'h0, blk = 1'h0;
  logic        ph, res, trip_mon, fail, retrip, start, blocked, ev_valid;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        reg_wr = 1'h0, reg_rd = 1'h0;
  logic [3:0]  ev_code;
  logic [47:0] ev_stamp;
  logic [15:0] seen = 16'h0;                // Event codes seen with a valid pulse.
  int          n_mismatch = 0, cmp_count = 0;

  breaker_failure_supervisor DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tick_i(tick_i),
    .phase_pickup_i(ph), .residual_pickup_i(res), .trip_monitor_i(trip_mon),
    .dedicated_input_i(ded_in), .block_i(blk), .timestamp_i(ts),
    .max_phase_current_i(16'h1234), .residual_current_i(16'h0ABC), .setting_group_i(3'h5),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .breaker_failure_output_o(fail), .retrip_o(retrip),
    .start_o(start), .blocked_o(blocked), .event_valid_o(ev_valid),
    .event_code_o(ev_code), .event_stamp_o(ev_stamp));
  breaker_plant plant (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tick_i(tick_i),
    .fault_i(fault), .trip_cmd_i(trip_cmd), .breaker_ok_i(brk_ok),
    .phase_pickup_o(ph), .residual_pickup_o(res), .trip_monitor_o(trip_mon));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, one tick every four clocks, and a time stamp that steps each clock.
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    ts     <= ts + 48'h1;
    div    <= div + 2'h1;
    tick_i <= (div == 2'h3);
  end
  // Collects emitted events; the stamp is the time of the emission cycle.
  always @(negedge clk_sys_i) begin
    if (ev_valid === 1'h1) begin
      seen[ev_code] = 1'h1;
      `CHK("event stamp", ts - 48'h1, ev_stamp)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic clk_n(int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic ticks(int n);
    repeat (n) @(posedge clk_sys_i iff tick_i);
    @(negedge clk_sys_i);
  endtask
  task automatic reg_write(logic [7:0] a, logic [31:0] w);
    @(posedge clk_sys_i);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'h1;
    @(posedge clk_sys_i);
    reg_wr <= 1'h0;
  endtask
  task automatic reg_read(logic [7:0] a);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys_i);
    reg_rd <= 1'h0;
    @(negedge clk_sys_i);
    d = reg_rdata;
  endtask
  // Sets the fault, the primary trip and the breaker health.
  task automatic drive(logic f, logic t, logic ok);
    @(posedge clk_sys_i);
    fault    <= f;
    trip_cmd <= t;
    brk_ok   <= ok;
  endtask
  task automatic set_mode(criterion_t m);
    reg_write(`CBF_A_CTRL, 32'h00FFFF04 | 32'(m));
  endtask
  // With a delay of 4 ticks the output is low after 3 ticks and high after 5.
  task automatic fail_window();
    ticks(3);
    `CHK("fail early", 1'h0, fail)
    ticks(2);
    clk_n(1);
    `CHK("fail late", 1'h1, fail)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    reg_read(`CBF_A_CTRL);
    `CHK("ctrl reset", 32'h00FFFF04, d)
    reg_read(`CBF_A_RTR_DLY);
    `CHK("retrip delay reset", 32'h00000014, d)
    reg_read(`CBF_A_FL_DLY);
    `CHK("fail delay reset", 32'h00000028, d)
    reg_write(`CBF_A_STATUS, 32'hFFFFFFFF);
    reg_write(8'h40, 32'hFFFFFFFF);
    reg_read(`CBF_A_STATUS);
    `CHK("status reset", 32'h0, d)
    reg_read(8'h40);
    `CHK("unmapped read", 32'h0, d)
    reg_write(`CBF_A_RTR_DLY, 32'h2);
    reg_write(`CBF_A_FL_DLY, 32'h4);
    reg_read(`CBF_A_FL_DLY);
    `CHK("fail delay", 32'h4, d)
  endtask
  task automatic s_current();
    set_mode(MODE_CURRENT);
    drive(1'h1, 1'h1, 1'h1);
    ticks(6);
    `CHK("cleared fail", 1'h0, fail)
    `CHK("cleared retrip", 1'h0, retrip)
    drive(1'h0, 1'h0, 1'h1);
    clk_n(4);
    drive(1'h1, 1'h0, 1'h0);
    fail_window();
    `CHK("retrip", 1'h1, retrip)
    drive(1'h0, 1'h0, 1'h1);
    clk_n(3);
    `CHK("fail drop", 1'h0, fail)
  endtask
  task automatic s_and();
    set_mode(MODE_CUR_AND_OUT);
    drive(1'h1, 1'h0, 1'h0);
    ticks(8);
    `CHK("frozen start", 1'h1, start)
    `CHK("frozen fail", 1'h0, fail)
    drive(1'h1, 1'h1, 1'h0);
    fail_window();
    drive(1'h1, 1'h0, 1'h0);
    clk_n(3);
    `CHK("trip drop", 1'h0, fail)
    drive(1'h1, 1'h1, 1'h0);
    ticks(3);
    `CHK("count restart", 1'h0, fail)
    drive(1'h0, 1'h0, 1'h1);
    clk_n(4);
  endtask
  task automatic s_or();
    set_mode(MODE_CUR_OR_OUT);
    drive(1'h0, 1'h1, 1'h0);
    fail_window();
    drive(1'h1, 1'h0, 1'h0);
    clk_n(3);
    `CHK("one holds", 1'h1, fail)
    drive(1'h0, 1'h0, 1'h0);
    clk_n(3);
    `CHK("both drop", 1'h0, fail)
    drive(1'h0, 1'h0, 1'h1);
    clk_n(2);
  endtask
  task automatic s_input();
    // Input mode with retrip disabled: the failure output may rise, the retrip output may not.
    reg_write(`CBF_A_CTRL, 32'h00FFFF03);
    drive(1'h1, 1'h1, 1'h0);
    ticks(8);
    `CHK("own trips", 1'h0, fail)
    `CHK("own start", 1'h0, start)
    @(posedge clk_sys_i) ded_in <= 1'h1;
    fail_window();
    `CHK("retrip off", 1'h0, retrip)
    @(posedge clk_sys_i) ded_in <= 1'h0;
    drive(1'h0, 1'h0, 1'h1);
    clk_n(3);
    `CHK("input drop", 1'h0, fail)
  endtask
  task automatic s_block();
    set_mode(MODE_CURRENT);
    @(posedge clk_sys_i) blk <= 1'h1;
    drive(1'h1, 1'h0, 1'h0);
    ticks(8);
    `CHK("blocked", 1'h1, blocked)
    `CHK("blocked start", 1'h0, start)
    `CHK("blocked fail", 1'h0, fail)
    drive(1'h0, 1'h0, 1'h1);
    clk_n(3);
    @(posedge clk_sys_i) blk <= 1'h0;
    clk_n(2);
    `CHK("unblocked", 1'h0, blocked)
    drive(1'h1, 1'h0, 1'h0);
    ticks(2);
    `CHK("start", 1'h1, start)
    @(posedge clk_sys_i) blk <= 1'h1;
    ticks(6);
    `CHK("released start", 1'h0, start)
    `CHK("released fail", 1'h0, fail)
    drive(1'h0, 1'h0, 1'h1);
    clk_n(3);
    @(posedge clk_sys_i) blk <= 1'h0;
    clk_n(2);
  endtask
  task automatic s_events();
    logic [31:0] cfg [2] = '{32'h00FF0004, 32'h0000FF04};
    logic [15:0] exp [2] = '{16'hFF00, 16'h00FF};
    for (int i = 0; i < 2; i++) begin
      reg_write(`CBF_A_CTRL, cfg[i]);
      clk_n(10);
      seen = 16'h0;
      @(posedge clk_sys_i) blk <= 1'h1;
      ded_in <= 1'h1;
      drive(1'h1, 1'h1, 1'h0);
      ticks(2);
      drive(1'h0, 1'h0, 1'h1);
      clk_n(3);
      @(posedge clk_sys_i) blk <= 1'h0;
      ded_in <= 1'h0;
      drive(1'h1, 1'h1, 1'h0);
      ticks(8);
      drive(1'h0, 1'h0, 1'h1);
      clk_n(30);
      `CHK("event set", exp[i], seen)
    end
  endtask
  task automatic s_counters();
    set_mode(MODE_CURRENT);
    reg_write(`CBF_A_CNT_CLR, 32'hF);
    drive(1'h1, 1'h0, 1'h0);
    ticks(8);
    drive(1'h0, 1'h0, 1'h1);
    clk_n(3);
    @(posedge clk_sys_i) blk <= 1'h1;
    drive(1'h1, 1'h0, 1'h0);
    clk_n(4);
    drive(1'h0, 1'h0, 1'h1);
    clk_n(3);
    @(posedge clk_sys_i) blk <= 1'h0;
    reg_read(`CBF_A_CNT_A);
    `CHK("retrip start count", 32'h00010001, d)
    reg_read(`CBF_A_CNT_B);
    `CHK("block fail count", 32'h00010001, d)
    reg_write(`CBF_A_CNT_CLR, 32'h1);
    reg_read(`CBF_A_CNT_A);
    `CHK("start count clear", 32'h00010000, d)
  endtask
  task automatic s_records();
    logic [3:0] last;
    reg_read(`CBF_A_STATUS);
    `CHK("record fill", 4'hC, d[7:4])
    `CHK("slot range", 1'h1, d[11:8] < 4'hC)
    last = (d[11:8] == 4'h0) ? 4'hB : d[11:8] - 4'h1;
    reg_write(`CBF_A_REC_SEL, {28'h0, last});
    reg_read(`CBF_A_REC_W1);
    `CHK("record phase", 16'h1234, d[31:16])
    reg_read(`CBF_A_REC_W3);
    `CHK("record group", {13'h00A, 16'h0ABC}, {d[31:19], d[15:0]})
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog at 40000 clocks: the tests need well under 1000 clocks.
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    clk_n(1);
    s_reset();
    s_current();
    s_and();
    s_or();
    s_input();
    s_block();
    s_events();
    s_counters();
    s_records();
    print_verdict();
  end
endmodule
